// *** hdl/adc_scan_control.sv ***
// scan control and observe cells of the converter
// Overview of operation
// - hold low makes the converter track, hold high freezes the sampled value.
// - the bypass select routes channels 0 to 3 around the gain stages, idle value 1.
// - the ground select ties the comparator negative input to ground, idle value 0.
// - the band-gap select puts the band-gap reference on the negative input, idle value 0.
// - the converter power enable switches the converter on, idle value 0.
// - the gain-stage power enable powers the amplifiers, idle value 0.
// - the gain path enable connects the gain output to the comparator, idle value 0.
// - the gain clock clocks the switched-capacitor stages and idles at 0.
//
// Our own choices: the placing of the registers and strobed register access.
module adc_scan_control
    import adc_scan_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic enable,
    input wire logic [3:0] address,
    input wire logic [31:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    output logic [31:0] readData,
    input wire logic comparatorIn,
    output logic sampleHold,
    output logic gainClock,
    output logic gain_path_enable,
    output logic bandgap_negative_select,
    output logic converter_power_enable,
    output logic gain_stage_power_enable,
    output logic bypass_path_select,
    output logic gain_ten_select,
    output logic gain_twenty_select,
    output logic negative_input_ground_select,
    output logic [DAC_WIDTH-1:0] dacValue,
    output logic comparatorObserved,
    output logic sampleDacError
);
    // the synchroniser taps and the field layout are sized for these values only
    if (DAC_WIDTH != 10 || SYNC_STAGES != 3) begin : g_sizeCheck
        $error("unsupported width or synchroniser depth");
    end

    typedef struct packed {
        logic [CTRL_WIDTH-1:0] ctrl;
        logic [DAC_WIDTH-1:0] dac;
        logic [SYNC_STAGES-1:0] sync;
        logic comp;
        logic sampleErr;
        logic [31:0] rdata;
    } state_t;

    state_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.rdata = 32'h0;
        // the comparator is analog and asynchronous to clock
        s_d.sync = {s_q.sync[SYNC_STAGES-2:0], comparatorIn};
        // power off forces a clean 0 regardless of the floating comparator,
        // even while the late stages still disagree
        if (!s_q.ctrl[CONV_POWER_BIT]) begin
            s_d.comp = 1'b0;
        end else if (s_q.sync[1] == s_q.sync[2]) begin
            // the observed result only changes once the two late stages agree
            s_d.comp = s_q.sync[2];
        end
        // dac moved during tracking: sticky, set wins over clear
        if (!s_q.ctrl[HOLD_BIT] && s_q.dac != DAC_MIDPOINT) begin
            s_d.sampleErr = 1'b1;
        end
        if (writeStrobe) begin
            case (address)
                CTRL_OFFSET: begin
                    s_d.ctrl = writeData[CTRL_WIDTH-1:0];
                end
                DAC_OFFSET: begin
                    s_d.dac = writeData[DAC_WIDTH-1:0];
                end
                STATUS_OFFSET: begin
                    if (writeData[1] && !(!s_q.ctrl[HOLD_BIT] && s_q.dac != DAC_MIDPOINT)) begin
                        s_d.sampleErr = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (readStrobe) begin
            case (address)
                CTRL_OFFSET: s_d.rdata = {22'h0, s_q.ctrl};
                DAC_OFFSET: s_d.rdata = {22'h0, s_q.dac};
                STATUS_OFFSET: s_d.rdata = {30'h0, s_q.sampleErr, s_q.comp};
                default: s_d.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_q <= '{ctrl: CTRL_RESET, dac: DAC_RESET, sync: '0, comp: 1'b0,
                     sampleErr: 1'b0, rdata: 32'h0};
        end else if (enable) begin
            s_q <= s_d;
        end
    end

    assign readData = s_q.rdata;
    assign sampleHold = s_q.ctrl[HOLD_BIT];
    assign gainClock = s_q.ctrl[GAIN_CLOCK_BIT];
    assign gain_path_enable = s_q.ctrl[GAIN_PATH_BIT];
    assign bandgap_negative_select = s_q.ctrl[BANDGAP_BIT];
    assign converter_power_enable = s_q.ctrl[CONV_POWER_BIT];
    assign gain_stage_power_enable = s_q.ctrl[GAIN_POWER_BIT];
    assign bypass_path_select = s_q.ctrl[BYPASS_BIT];
    assign gain_ten_select = s_q.ctrl[GAIN_TEN_BIT];
    assign gain_twenty_select = s_q.ctrl[GAIN_TWENTY_BIT];
    assign negative_input_ground_select = s_q.ctrl[GROUND_BIT];
    assign dacValue = s_q.dac;
    assign comparatorObserved = s_q.comp;
    assign sampleDacError = s_q.sampleErr;

    sequence s_ctrlWrite;
        enable && writeStrobe && address == CTRL_OFFSET;
    endsequence

    property p_holdWrite;
        @(posedge clock) disable iff (!resetn)
        s_ctrlWrite |=> sampleHold == $past(writeData[HOLD_BIT]);
    endproperty
    a_holdWrite: assert property (p_holdWrite) else $error("hold not taken");

    property p_bypassWrite;
        @(posedge clock) disable iff (!resetn)
        s_ctrlWrite |=> bypass_path_select == $past(writeData[BYPASS_BIT]);
    endproperty
    a_bypassWrite: assert property (p_bypassWrite) else $error("bypass wrong");

    property p_groundWrite;
        @(posedge clock) disable iff (!resetn)
        s_ctrlWrite |=> negative_input_ground_select == $past(writeData[GROUND_BIT]);
    endproperty
    a_groundWrite: assert property (p_groundWrite) else $error("ground wrong");

    property p_bandgapWrite;
        @(posedge clock) disable iff (!resetn)
        s_ctrlWrite |=> bandgap_negative_select == $past(writeData[BANDGAP_BIT]);
    endproperty
    a_bandgapWrite: assert property (p_bandgapWrite) else $error("bandgap wrong");

    property p_powerWrite;
        @(posedge clock) disable iff (!resetn)
        s_ctrlWrite |=> converter_power_enable == $past(writeData[CONV_POWER_BIT]);
    endproperty
    a_powerWrite: assert property (p_powerWrite) else $error("power wrong");

    property p_ampWrite;
        @(posedge clock) disable iff (!resetn)
        s_ctrlWrite |=> gain_stage_power_enable == $past(writeData[GAIN_POWER_BIT]);
    endproperty
    a_ampWrite: assert property (p_ampWrite) else $error("amp power wrong");

    property p_pathWrite;
        @(posedge clock) disable iff (!resetn)
        s_ctrlWrite |=> gain_path_enable == $past(writeData[GAIN_PATH_BIT]);
    endproperty
    a_pathWrite: assert property (p_pathWrite) else $error("gain path wrong");

    property p_clockWrite;
        @(posedge clock) disable iff (!resetn)
        s_ctrlWrite |=> gainClock == $past(writeData[GAIN_CLOCK_BIT]);
    endproperty
    a_clockWrite: assert property (p_clockWrite) else $error("gain clock wrong");

    property p_idleComp;
        @(posedge clock) disable iff (!resetn)
        !converter_power_enable && enable |=> !comparatorObserved;
    endproperty
    a_idleComp: assert property (p_idleComp) else $error("comparator not 0 idle");

    property p_sampleErr;
        @(posedge clock) disable iff (!resetn)
        enable && !sampleHold && dacValue != DAC_MIDPOINT |=> sampleDacError;
    endproperty
    a_sampleErr: assert property (p_sampleErr) else $error("sample dac miss");

    sequence s_dacWrite;
        enable && writeStrobe && address == DAC_OFFSET;
    endsequence

    sequence s_statusClear;
        enable && writeStrobe && address == STATUS_OFFSET && writeData[1] && sampleHold;
    endsequence

    property p_dacWrite;
        @(posedge clock) disable iff (!resetn)
        s_dacWrite |=> dacValue == $past(writeData[DAC_WIDTH-1:0]);
    endproperty
    a_dacWrite: assert property (p_dacWrite) else $error("dac value not taken");

    property p_statusClear;
        @(posedge clock) disable iff (!resetn)
        s_statusClear |=> !sampleDacError;
    endproperty
    a_statusClear: assert property (p_statusClear) else $error("error flag not cleared");

    property p_tenWrite;
        @(posedge clock) disable iff (!resetn)
        s_ctrlWrite |=> gain_ten_select == $past(writeData[GAIN_TEN_BIT]);
    endproperty
    a_tenWrite: assert property (p_tenWrite) else $error("gain ten wrong");

    property p_twentyWrite;
        @(posedge clock) disable iff (!resetn)
        s_ctrlWrite |=> gain_twenty_select == $past(writeData[GAIN_TWENTY_BIT]);
    endproperty
    a_twentyWrite: assert property (p_twentyWrite) else $error("gain twenty wrong");

    property p_compTrack;
        @(posedge clock) disable iff (!resetn)
        enable && converter_power_enable && s_q.sync[1] == s_q.sync[2]
            |=> comparatorObserved == $past(s_q.sync[2]);
    endproperty
    a_compTrack: assert property (p_compTrack) else $error("comparator not followed");
endmodule

// *** hdl/adc_scan_pkg.sv ***
// constants for the converter scan control block
package adc_scan_pkg;
    localparam int DAC_WIDTH = 10;
    localparam int SYNC_STAGES = 3;
    // register offsets on the plain register port
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] DAC_OFFSET = 4'h1;
    localparam logic [3:0] STATUS_OFFSET = 4'h2;
    localparam logic [3:0] ANALOG_OFFSET = 4'h3;
    // control field positions
    localparam int HOLD_BIT = 0;
    localparam int GAIN_CLOCK_BIT = 1;
    localparam int GAIN_PATH_BIT = 2;
    localparam int BANDGAP_BIT = 3;
    localparam int CONV_POWER_BIT = 4;
    localparam int GAIN_POWER_BIT = 5;
    localparam int BYPASS_BIT = 6;
    localparam int GAIN_TEN_BIT = 7;
    localparam int GAIN_TWENTY_BIT = 8;
    localparam int GROUND_BIT = 9;
    localparam int CTRL_WIDTH = 10;
    // idle values after reset: hold high, bypass high, all other controls low, dac at midpoint
    localparam logic [9:0] CTRL_RESET = 10'h041;
    localparam logic [9:0] DAC_RESET = 10'h200;
    localparam logic [9:0] DAC_MIDPOINT = 10'h200;
endpackage

// *** sim/adc_converter_model.sv ***
// behavioural converter front end: sample-and-hold and comparator against the dac code
module adc_converter_model
    import adc_scan_pkg::*;
(
    input wire logic sampleHold,
    input wire logic powerOn,
    input wire logic [DAC_WIDTH-1:0] dacValue,
    input wire logic [DAC_WIDTH-1:0] analogLevel,
    output logic comparatorOut
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DAC_WIDTH-1:0] heldLevel;
    always_latch begin
        if (!sampleHold) begin
            heldLevel <= analogLevel;
        end
    end
    // unpowered comparator stays low so a dead converter never looks like a pass
    assign comparatorOut = powerOn & (dacValue > heldLevel);
endmodule

// *** sim/adc_scan_control_bench.sv ***
// self-checking bench for the converter scan control block
module adc_scan_control_bench;
    import adc_scan_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, resetn, enable, writeStrobe, readStrobe, comparatorIn, sampleHold, gainClock;
    logic gainPath, bandgapSel, convPower, gainPower, bypassSel, gainTen, gainTwenty, groundSel;
    logic comparatorObserved, sampleDacError;
    logic [3:0] address;
    logic [31:0] writeData, readData;
    logic [DAC_WIDTH-1:0] dacValue, analogLevel;
    logic [9:0] ctrlSeen;
    int failures = 0;
    int samplesChecked = 0;
    localparam logic [31:0] PWR = 32'h10;
    assign ctrlSeen = {groundSel, gainTwenty, gainTen, bypassSel, gainPower, convPower,
        bandgapSel, gainPath, gainClock, sampleHold};
    adc_scan_control uut (.clock(clock), .resetn(resetn), .enable(enable), .address(address),
        .writeData(writeData), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
        .readData(readData), .comparatorIn(comparatorIn), .sampleHold(sampleHold),
        .gainClock(gainClock), .gain_path_enable(gainPath), .bandgap_negative_select(bandgapSel),
        .converter_power_enable(convPower), .gain_stage_power_enable(gainPower),
        .bypass_path_select(bypassSel), .gain_ten_select(gainTen),
        .gain_twenty_select(gainTwenty), .negative_input_ground_select(groundSel),
        .dacValue(dacValue), .comparatorObserved(comparatorObserved),
        .sampleDacError(sampleDacError));
    adc_converter_model converter (.sampleHold(sampleHold), .powerOn(convPower),
        .dacValue(dacValue), .analogLevel(analogLevel), .comparatorOut(comparatorIn));
    task automatic test_done();
        $display("checks %0d mismatches %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] got);
        samplesChecked++;
        if (got !== expv) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, expv, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        address <= a;
        writeData <= d;
        writeStrobe <= 1'b1;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] expv);
        @(posedge clock);
        address <= a;
        readStrobe <= 1'b1;
        @(posedge clock);
        readStrobe <= 1'b0;
        @(negedge clock);
        chk("read data", expv, readData);
        @(negedge clock);
        chk("read data stands one cycle", 32'h0, readData);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        repeat (5000) @(posedge clock);
        failures++;
        $display("[FAIL] watchdog expected done seen hang");
        test_done();
    end
    initial begin
        resetn = 1'b0;
        enable = 1'b1;
        address = 4'h0;
        writeData = 32'h0;
        writeStrobe = 1'b0;
        readStrobe = 1'b0;
        analogLevel = 10'h180;
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        settle(8);
        chk("idle controls", {22'h0, CTRL_RESET}, {22'h0, ctrlSeen});
        chk("idle dac", {22'h0, DAC_RESET}, {22'h0, dacValue});
        chk("idle comparator", 32'h0, {31'h0, comparatorObserved});
        rd(STATUS_OFFSET, 32'h0);
        $display("test idle done");
        for (int i = 0; i < CTRL_WIDTH; i++) begin
            wr(CTRL_OFFSET, 32'h1 << i);
            settle(0);
            chk("control bit", 32'h1 << i, {22'h0, ctrlSeen});
        end
        rd(ANALOG_OFFSET, 32'h0);
        rd(4'hf, 32'h0);
        wr(ANALOG_OFFSET, 32'h3ff);
        settle(0);
        chk("unmapped write", 32'h200, {22'h0, ctrlSeen});
        $display("test controls done");
        // sample with the dac parked at midpoint, gain stages left unused
        wr(CTRL_OFFSET, PWR | 32'h40);
        settle(4);
        wr(CTRL_OFFSET, PWR | 32'h41);
        wr(DAC_OFFSET, 32'h100);
        // move the input only once hold has settled, so the latch cannot race the hold edge
        analogLevel <= 10'h300;
        settle(8);
        chk("low limit", 32'h0, {31'h0, comparatorObserved});
        wr(DAC_OFFSET, 32'h280);
        settle(8);
        chk("high limit held", 32'h1, {31'h0, comparatorObserved});
        rd(STATUS_OFFSET, 32'h1);
        $display("test limits done");
        wr(CTRL_OFFSET, PWR);
        wr(CTRL_OFFSET, PWR | 32'h1);
        settle(8);
        chk("error flag", 32'h1, {31'h0, sampleDacError});
        rd(STATUS_OFFSET, 32'h2);
        wr(STATUS_OFFSET, 32'h2);
        rd(STATUS_OFFSET, 32'h0);
        $display("test sample error done");
        @(posedge clock);
        enable <= 1'b0;
        wr(CTRL_OFFSET, {22'h0, CTRL_RESET});
        enable <= 1'b1;
        settle(0);
        chk("frozen controls", PWR | 32'h1, {22'h0, ctrlSeen});
        wr(CTRL_OFFSET, {22'h0, CTRL_RESET});
        wr(DAC_OFFSET, 32'h200);
        settle(8);
        chk("powered off comparator", 32'h0, {31'h0, comparatorObserved});
        $display("test enable and power done");
        test_done();
    end
endmodule
